// File: src/scc_pkg.sv
package scc_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] SCC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SCC_BAUD_ADDR = 8'h04;
   localparam logic [7:0] SCC_TXDATA_ADDR = 8'h08;
   localparam logic [7:0] SCC_FLAGS_ADDR = 8'h0C;
   localparam logic [7:0] SCC_IRQ_STAT_ADDR = 8'h10;
   localparam logic [7:0] SCC_IRQ_MASK_ADDR = 8'h14;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] SCC_CTRL_RST = 8'h00;
   localparam logic [1:0] SCC_BAUD_RST = 2'h0;
   localparam logic [7:0] SCC_TXDATA_RST = 8'h00;
   localparam logic [3:0] SCC_IRQ_RST = 4'h0;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int SCC_TX_EMPTY_IRQ_EN = 7;
   localparam int SCC_RX_IRQ_EN = 6;
   localparam int SCC_TRANSMIT_ENABLE = 5;
   localparam int SCC_RECEIVE_ENABLE = 4;
   localparam int SCC_RESERVED_BIT3 = 3;
   localparam int SCC_TX_END_IRQ_EN = 2;
   localparam int SCC_CLK_ENABLE_HI = 1;
   localparam int SCC_CLK_ENABLE_LO = 0;

   // ************************************************************
   // Interrupt status and mask fields
   // ************************************************************
   localparam int SCC_IRQ_TX_EMPTY = 0;
   localparam int SCC_IRQ_RX_FULL = 1;
   localparam int SCC_IRQ_RX_ERROR = 2;
   localparam int SCC_IRQ_TX_END = 3;
   localparam int SCC_IRQ_COUNT = 4;

   // ************************************************************
   // Baud generator source selection
   // ************************************************************
   typedef enum logic [1:0] {
      SCC_SRC_SYS = 2'b00,
      SCC_SRC_SUB = 2'b01,
      SCC_SRC_DIV16 = 2'b10,
      SCC_SRC_DIV64 = 2'b11
   } scc_src_type;

   localparam logic [5:0] SCC_DIV16_LAST = 6'h0F;
   localparam logic [5:0] SCC_DIV64_LAST = 6'h3F;

endpackage : scc_pkg

// File: src/scc_clk_if.sv
`timescale 1ns/100ps

interface scc_clk_if;
   import scc_pkg::*;
   scc_src_type src_sel;
   logic sub_mode;
   logic sub_tick;
   logic baud_tick;

   modport ctrl (
      output src_sel,
      output sub_mode,
      output sub_tick,
      input baud_tick
   );

   modport gen (
      input src_sel,
      input sub_mode,
      input sub_tick,
      output baud_tick
   );
endinterface : scc_clk_if

// File: src/scc_baud_src.sv
`timescale 1ns/100ps

module scc_baud_src (
   input wire logic clk, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   scc_clk_if.gen clk_port // Source selection and tick
);
   import scc_pkg::*;

   logic [5:0] div_reg;
   logic sub_half_reg;
   logic tick_next;
   logic tick_reg;

   // ************************************************************
   // Free running system clock prescaler
   // ************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 6'h00;
      end else begin
         div_reg <= div_reg + 6'h01;
      end
   end

   // Subclock halver, bypassed in the sub power modes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sub_half_reg <= 1'b0;
      end else if (clk_port.sub_tick) begin
         sub_half_reg <= ~sub_half_reg;
      end
   end

   always_comb begin
      case (clk_port.src_sel)
         SCC_SRC_SYS: tick_next = 1'b1;
         SCC_SRC_SUB: begin
            tick_next = clk_port.sub_tick &
               (clk_port.sub_mode | sub_half_reg);
         end
         SCC_SRC_DIV16: tick_next = (div_reg[3:0] == SCC_DIV16_LAST[3:0]);
         SCC_SRC_DIV64: tick_next = (div_reg == SCC_DIV64_LAST);
         default: tick_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= tick_next;
      end
   end

   assign clk_port.baud_tick = tick_reg;

endmodule : scc_baud_src

// File: src/scc_ctrl.sv
// Behaviour
// - Two-bit source select: system, subclock, system/16, system/64.
// - Subclock halved in active and sleep, undivided in sub modes.
// - Control register clears on reset, standby, module standby, watch.
// - All control bits readable and writable at any time; the code ignores writes in standby, module standby, watch.
// - Transmit-empty request while bit 7 and empty flag both set.
// - Bit 6 gates receive-full and receive-error (overrun/framing/parity).
// - Receive requests drop when flags or bit 6 clear.
// - Transmit disabled: pin is port, empty flag held at one.
// - Transmit enabled: pin serial; data write clears empty, starts.
// - Receive disabled: pin is port; receive flags left unchanged.
// - Reception starts on start bit (async) or clock input (sync).
// - Bit 3 is reserved and has no effect.
// - Bit 2 enables transmit-end request when no data at last bit.
// - Transmit-end request drops when flags or its enable clear.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps

module scc_ctrl (
   input wire logic clk, // System clock, 40 MHz
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high for write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic standby_mode, // Standby power mode
   input wire logic module_standby, // Module standby
   input wire logic watch_mode, // Watch power mode
   input wire logic sub_mode, // Subactive or subsleep mode
   input wire logic sub_tick, // One pulse per subclock period
   input wire logic sync_mode, // Clocked synchronous mode
   input wire logic tx_load, // Pulse: holding data moved to shifter
   input wire logic rx_buffer_full_flag, // Receive holding full
   input wire logic overrun_flag, // Overrun error
   input wire logic framing_error_flag, // Framing error
   input wire logic parity_error_flag, // Parity error
   input wire logic tx_complete_flag, // No data at last bit
   input wire logic rxd_in, // Receive pin level
   input wire logic sck_in, // Serial clock pin level
   output logic baud_tick, // Baud generator source tick
   output logic [7:0] tx_holding_reg, // Transmit data
   output logic tx_start, // Pulse: transmission starts
   output logic tx_pin_serial, // High: transmit pin carries data
   output logic rx_pin_serial, // High: receive pin is data input
   output logic rx_begin, // Pulse: reception starts
   output logic [1:0] sck_mode, // Clock enable field
   output logic tx_empty_irq, // Transmit-empty request
   output logic rx_full_irq, // Receive-full request
   output logic rx_error_irq, // Receive-error request
   output logic tx_end_irq, // Transmit-end request
   output logic irq // Combined masked interrupt, level
);
   import scc_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   // Register state
   logic [7:0] serial_control_reg;
   logic [1:0] baud_sel_reg;
   logic [7:0] txdata_reg;
   logic tx_buffer_empty_flag;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;

   // Request pipeline
   logic [3:0] req_next;
   logic [3:0] req_reg;
   logic irq_reg;

   // Bus answer
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // Link pulses and history
   logic tx_start_reg;
   logic rx_begin_reg;
   logic rxd_prev_reg;
   logic sck_prev_reg;

   // Decode
   logic setup;
   logic wr_en;
   logic low_power;
   logic mapped;
   logic tx_en;
   logic rx_en;

   scc_clk_if clk_bus ();

   // ************************************************************
   // APB decode
   // ************************************************************
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   // Power states clear control
   assign low_power = standby_mode | module_standby | watch_mode;
   assign tx_en = serial_control_reg[SCC_TRANSMIT_ENABLE];
   assign rx_en = serial_control_reg[SCC_RECEIVE_ENABLE];

   // Unmapped offsets: pslverr
   always_comb begin
      case (paddr)
         SCC_CTRL_ADDR: mapped = 1'b1;
         SCC_BAUD_ADDR: mapped = 1'b1;
         SCC_TXDATA_ADDR: mapped = 1'b1;
         SCC_FLAGS_ADDR: mapped = 1'b1;
         SCC_IRQ_STAT_ADDR: mapped = 1'b1;
         SCC_IRQ_MASK_ADDR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Answer in the cycle after setup: one access cycle, no wait states
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
      end
   end

   // Held until the next read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata_reg <= 32'h0000_0000;
         case (paddr)
            SCC_CTRL_ADDR: prdata_reg[7:0] <= serial_control_reg;
            SCC_BAUD_ADDR: prdata_reg[1:0] <= baud_sel_reg;
            SCC_TXDATA_ADDR: prdata_reg[7:0] <= txdata_reg;
            SCC_FLAGS_ADDR: begin
               prdata_reg[5:0] <= {tx_buffer_empty_flag,
                  rx_buffer_full_flag, overrun_flag,
                  framing_error_flag, parity_error_flag,
                  tx_complete_flag};
            end
            SCC_IRQ_STAT_ADDR: prdata_reg[3:0] <= irq_stat_reg;
            SCC_IRQ_MASK_ADDR: prdata_reg[3:0] <= irq_mask_reg;
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Serial control register
   // ************************************************************
   // Bit 3 is stored for read-back only; nothing else reads it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_control_reg <= SCC_CTRL_RST;
      end else if (low_power) begin
         serial_control_reg <= SCC_CTRL_RST;
      end else if (wr_en && paddr == SCC_CTRL_ADDR) begin
         serial_control_reg <= pwdata[7:0];
      end
   end

   // ************************************************************
   // Baud source selection
   // ************************************************************
   // Cleared with control
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         baud_sel_reg <= SCC_BAUD_RST;
      end else if (low_power) begin
         baud_sel_reg <= SCC_BAUD_RST;
      end else if (wr_en && paddr == SCC_BAUD_ADDR) begin
         baud_sel_reg <= pwdata[1:0];
      end
   end

   // Source generator inputs
   assign clk_bus.src_sel = scc_src_type'(baud_sel_reg);
   assign clk_bus.sub_mode = sub_mode;
   assign clk_bus.sub_tick = sub_tick;
   assign baud_tick = clk_bus.baud_tick;

   scc_baud_src u_baud_src (
      .clk(clk),
      .rst_b(rst_b),
      .clk_port(clk_bus.gen)
   );

   // ************************************************************
   // Transmit holding data and empty flag
   // ************************************************************
   // Kept through low power
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txdata_reg <= SCC_TXDATA_RST;
      end else if (wr_en && paddr == SCC_TXDATA_ADDR) begin
         txdata_reg <= pwdata[7:0];
      end
   end

   // Setting conditions win over a data write in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (!tx_en || low_power) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (tx_load) begin
         tx_buffer_empty_flag <= 1'b1;
      end else if (wr_en && paddr == SCC_TXDATA_ADDR) begin
         tx_buffer_empty_flag <= 1'b0;
      end
   end

   // Pulse only when enabled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_start_reg <= 1'b0;
      end else begin
         tx_start_reg <= wr_en & (paddr == SCC_TXDATA_ADDR) & tx_en &
            ~low_power;
      end
   end

   // ************************************************************
   // Reception start detection
   // ************************************************************
   // Reset to idle: no false edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rxd_prev_reg <= 1'b1;
         sck_prev_reg <= 1'b1;
      end else begin
         rxd_prev_reg <= rxd_in;
         sck_prev_reg <= sck_in;
      end
   end

   // Falling edge of the line is a start bit; falling clock edge in sync
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_begin_reg <= 1'b0;
      end else if (!rx_en || low_power) begin
         rx_begin_reg <= 1'b0;
      end else if (sync_mode) begin
         rx_begin_reg <= sck_prev_reg & ~sck_in;
      end else begin
         rx_begin_reg <= rxd_prev_reg & ~rxd_in;
      end
   end

   // ************************************************************
   // Interrupt requests
   // ************************************************************
   always_comb begin
      req_next[SCC_IRQ_TX_EMPTY] =
         serial_control_reg[SCC_TX_EMPTY_IRQ_EN] &
         tx_buffer_empty_flag;
      req_next[SCC_IRQ_RX_FULL] =
         serial_control_reg[SCC_RX_IRQ_EN] &
         rx_buffer_full_flag;
      req_next[SCC_IRQ_RX_ERROR] =
         serial_control_reg[SCC_RX_IRQ_EN] &
         (overrun_flag | framing_error_flag |
         parity_error_flag);
      req_next[SCC_IRQ_TX_END] =
         serial_control_reg[SCC_TX_END_IRQ_EN] &
         tx_complete_flag;
   end

   // Flop per request pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_reg <= SCC_IRQ_RST;
      end else begin
         req_reg <= req_next;
      end
   end

   // Sticky status per request; a new request beats a W1C clear
   genvar gi;
   generate
      for (gi = 0; gi < SCC_IRQ_COUNT; gi = gi + 1) begin : g_stat
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               irq_stat_reg[gi] <= 1'b0;
            end else if (req_next[gi] & ~req_reg[gi]) begin
               irq_stat_reg[gi] <= 1'b1;
            end else if (wr_en && paddr == SCC_IRQ_STAT_ADDR &&
                  pwdata[gi]) begin
               irq_stat_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // One enables a status bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_reg <= SCC_IRQ_RST;
      end else if (wr_en && paddr == SCC_IRQ_MASK_ADDR) begin
         irq_mask_reg <= pwdata[3:0];
      end
   end

   // Level, from masked status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   assign tx_holding_reg = txdata_reg;
   assign tx_start = tx_start_reg;
   assign tx_pin_serial = tx_en;
   assign rx_pin_serial = rx_en;
   assign rx_begin = rx_begin_reg;

   assign sck_mode = serial_control_reg[SCC_CLK_ENABLE_HI:
      SCC_CLK_ENABLE_LO];
   // Request pins
   assign tx_empty_irq = req_reg[SCC_IRQ_TX_EMPTY];
   assign rx_full_irq = req_reg[SCC_IRQ_RX_FULL];
   assign rx_error_irq = req_reg[SCC_IRQ_RX_ERROR];
   assign tx_end_irq = req_reg[SCC_IRQ_TX_END];
   assign irq = irq_reg;

endmodule : scc_ctrl

// File: verification/scc_ctrl_assertions.sv
`timescale 1ns/100ps

module scc_ctrl_assertions (
   input wire logic clk, // clock
   input wire logic rst_b, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [7:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic pready, // apb
   input wire logic standby_mode, // power
   input wire logic module_standby, // power
   input wire logic watch_mode, // power
   input wire logic sync_mode, // mode
   input wire logic rx_buffer_full_flag, // flag
   input wire logic overrun_flag, // flag
   input wire logic framing_error_flag, // flag
   input wire logic parity_error_flag, // flag
   input wire logic tx_complete_flag, // flag
   input wire logic rxd_in, // pin
   input wire logic sck_in, // pin
   input wire logic baud_tick, // tick
   input wire logic tx_start, // pulse
   input wire logic tx_pin_serial, // pin use
   input wire logic rx_pin_serial, // pin use
   input wire logic rx_begin, // pulse
   input wire logic [1:0] sck_mode, // field
   input wire logic rx_full_irq, // request
   input wire logic rx_error_irq, // request
   input wire logic tx_end_irq // request
);
   import scc_pkg::*;
   logic [7:0] csh;
   logic [1:0] bsh;
   logic [6:0] gap;
   logic lp;
   logic wok;
   assign lp = standby_mode | module_standby | watch_mode;
   assign wok = psel & penable & pready & pwrite;

   // ********
   // Shadow of written settings
   // ********
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         csh <= 8'h00;
         bsh <= 2'h0;
      end else if (lp) begin
         csh <= 8'h00;
         bsh <= 2'h0;
      end else if (wok && paddr == SCC_CTRL_ADDR) begin
         csh <= pwdata[7:0];
      end else if (wok && paddr == SCC_BAUD_ADDR) begin
         bsh <= pwdata[1:0];
      end
   end

   // Cycles since the last baud tick
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 7'h00;
      end else if (baud_tick) begin
         gap <= 7'h00;
      end else begin
         gap <= gap + 7'h01;
      end
   end

   // ********
   // Checks
   // ********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_rx_full_req: assert property (
      !$past(lp) |-> rx_full_irq == $past(csh[6] & rx_buffer_full_flag))
      else $error("rx_full_irq wrong");
   a_rx_err_req: assert property (
      !$past(lp) |-> rx_error_irq == $past(csh[6] & (overrun_flag
      | framing_error_flag | parity_error_flag)))
      else $error("rx_error_irq wrong");
   a_tx_end_req: assert property (
      !$past(lp) |-> tx_end_irq == $past(csh[2] & tx_complete_flag))
      else $error("tx_end_irq wrong");
   a_pins_follow: assert property (
      csh == $past(csh) |-> {tx_pin_serial, rx_pin_serial, sck_mode}
      == {csh[5:4], csh[1:0]})
      else $error("pin use differs from control");
   a_lp_clears: assert property (
      lp [*2] |=> !tx_pin_serial && !rx_pin_serial && sck_mode == 2'h0)
      else $error("low power did not clear control");
   a_baud_sys: assert property (
      bsh == 2'h0 && $past(bsh) == 2'h0 && $past(rst_b) |-> baud_tick)
      else $error("system source missed a tick");
   a_div16_gap: assert property (
      baud_tick && bsh == 2'h2 && $past(bsh, 16) == 2'h2 |-> gap == 7'd15)
      else $error("divide by 16 spacing wrong");
   a_div64_gap: assert property (
      baud_tick && bsh == 2'h3 && $past(bsh, 64) == 2'h3 |-> gap == 7'd63)
      else $error("divide by 64 spacing wrong");
   a_rx_start: assert property (
      (sync_mode ? $fell(sck_in) : $fell(rxd_in)) && rx_pin_serial
      && $past(rx_pin_serial) |-> ##[1:3] rx_begin)
      else $error("reception did not start");
   a_rx_quiet: assert property (
      !rx_pin_serial && !$past(rx_pin_serial) |-> !rx_begin)
      else $error("reception while disabled");
   a_apb_ready: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("ready not one access cycle");
   a_tx_start: assert property (
      wok && paddr == SCC_TXDATA_ADDR && !lp |=> tx_start == $past(csh[5]))
      else $error("tx_start wrong after data write");

   c_tx_start: cover property (tx_start);
   c_rx_begin: cover property (rx_begin);
   c_rx_irq: cover property (rx_full_irq && rx_error_irq);
endmodule : scc_ctrl_assertions

bind scc_ctrl scc_ctrl_assertions u_chk (.clk, .rst_b, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .standby_mode, .module_standby,
   .watch_mode, .sync_mode, .rx_buffer_full_flag, .overrun_flag,
   .framing_error_flag, .parity_error_flag, .tx_complete_flag, .rxd_in,
   .sck_in, .baud_tick, .tx_start, .tx_pin_serial, .rx_pin_serial,
   .rx_begin, .sck_mode, .rx_full_irq, .rx_error_irq, .tx_end_irq);

// File: verification/scc_line_partner.sv
`timescale 1ns/100ps

module scc_line_partner (
   input wire logic clk, // system clock
   input wire logic go_async, // pulse: send one frame
   input wire logic go_sync, // pulse: one clock pulse
   output logic rxd_in, // data line, idles high
   output logic sck_in // serial clock, idles high
);
   // ********
   // Far-side sender
   // ********
   initial begin
      rxd_in = 1'b1;
      sck_in = 1'b1;
   end

   always @(posedge clk) begin
      if (go_async) begin
         rxd_in <= 1'b0;
         repeat (16) @(posedge clk);
         rxd_in <= 1'b1;
         repeat (144) @(posedge clk);
      end else if (go_sync) begin
         sck_in <= 1'b0;
         repeat (8) @(posedge clk);
         sck_in <= 1'b1;
      end
   end
endmodule : scc_line_partner

// File: verification/tb_serial_control_clock_select.sv
`timescale 1ns/100ps

module tb_serial_control_clock_select;
   import scc_pkg::*;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0] paddr, tx_holding_reg, outs;
   logic [31:0] pwdata, prdata, rdq;
   logic standby_mode, module_standby, watch_mode, sub_mode, sub_tick;
   logic sync_mode, tx_load, rxd_in, sck_in, go_async, go_sync;
   logic rx_buffer_full_flag, overrun_flag, framing_error_flag;
   logic parity_error_flag, tx_complete_flag, irq;
   logic baud_tick, tx_start, tx_pin_serial, rx_pin_serial, rx_begin;
   logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
   logic [1:0] sck_mode, sc;
   logic [4:0] fl;
   logic [2:0] lpv;
   int num_errors, n_checks, n_tick, n_start, n_begin, t0;
   logic [7:0] rc [10] = '{8'h80, 8'h40, 8'h40, 8'h40, 8'h40, 8'h00,
      8'h04, 8'h08, 8'h33, 8'hFF};
   logic [4:0] rf [10] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h1E,
      5'h01, 5'h1F, 5'h00, 5'h1F};
   logic [7:0] re [10] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h20, 8'h00,
      8'h10, 8'h00, 8'h0F, 8'hFF};

   assign {standby_mode, module_standby, watch_mode} = lpv;
   assign {rx_buffer_full_flag, overrun_flag, framing_error_flag,
      parity_error_flag, tx_complete_flag} = fl;
   assign outs = {tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq,
      tx_pin_serial, rx_pin_serial, sck_mode};

   scc_ctrl dut (.*);
   scc_line_partner u_line (.clk(clk), .go_async(go_async),
      .go_sync(go_sync), .rxd_in(rxd_in), .sck_in(sck_in));

   // ********
   // Clock, subclock ticks and event counters
   // ********
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      sc <= sc + 2'h1;
      sub_tick <= (sc == 2'h3);
      if (baud_tick === 1'b1) n_tick <= n_tick + 1;
      if (tx_start === 1'b1) n_start <= n_start + 1;
      if (rx_begin === 1'b1) n_begin <= n_begin + 1;
   end

   // ********
   // Tasks
   // ********
   task chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rdq, e);
   endtask : rdc

   task bcount(input logic [1:0] s, input logic m, input int n, int e);
      wr(SCC_BAUD_ADDR, {30'h0, s});
      sub_mode <= m;
      repeat (70) @(posedge clk);
      t0 = n_tick;
      repeat (n) @(posedge clk);
      chk("baud_ticks", n_tick - t0, e);
   endtask : bcount

   task send(input logic s);
      sync_mode <= s;
      go_sync <= s;
      go_async <= !s;
      @(posedge clk);
      go_sync <= 1'b0;
      go_async <= 1'b0;
      repeat (180) @(posedge clk);
   endtask : send

   task complete_run;
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      complete_run();
   end

   // ********
   // Main sequence
   // ********
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {sub_mode, sub_tick, sync_mode, tx_load, go_async, go_sync} = '0;
      {fl, lpv, sc} = '0;
      {num_errors, n_checks, n_tick, n_start, n_begin} = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc("ctrl_rst", SCC_CTRL_ADDR, 32'h0);
      rdc("flags_rst", SCC_FLAGS_ADDR, 32'h20);
      for (int i = 0; i < 10; i++) begin
         wr(SCC_CTRL_ADDR, {24'h0, rc[i]});
         fl <= rf[i];
         repeat (3) @(posedge clk);
         chk("outs", outs, re[i]);
         rdc("ctrl_rd", SCC_CTRL_ADDR, {24'h0, rc[i]});
         rdc("flags_rd", SCC_FLAGS_ADDR, {27'h1, rf[i]});
      end
      rdc("irq_stat", SCC_IRQ_STAT_ADDR, 32'h0F);
      chk("irq_masked", irq, 1'b0);
      wr(SCC_IRQ_MASK_ADDR, 32'h02);
      repeat (3) @(posedge clk);
      chk("irq_on", irq, 1'b1);
      wr(SCC_CTRL_ADDR, 32'h0);
      fl <= 5'h00;
      repeat (3) @(posedge clk);
      wr(SCC_IRQ_STAT_ADDR, 32'h0F);
      rdc("irq_clr", SCC_IRQ_STAT_ADDR, 32'h0);
      chk("irq_off", irq, 1'b0);
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", rerr, 1'b1);
      chk("unmapped", rdq, 32'h0);
      // Transmit side, enables set after the format is settled
      wr(SCC_CTRL_ADDR, 32'hA0);
      t0 = n_start;
      wr(SCC_TXDATA_ADDR, 32'h5A);
      @(posedge clk);
      chk("tx_start", n_start - t0, 1);
      chk("tx_data", tx_holding_reg, 8'h5A);
      chk("tx_empty_irq", tx_empty_irq, 1'b0);
      rdc("flags_tx", SCC_FLAGS_ADDR, 32'h0);
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      repeat (3) @(posedge clk);
      chk("tx_empty_back", tx_empty_irq, 1'b1);
      wr(SCC_TXDATA_ADDR, 32'hC3);
      wr(SCC_CTRL_ADDR, 32'h80);
      rdc("flags_te0", SCC_FLAGS_ADDR, 32'h20);
      // Receive side
      wr(SCC_CTRL_ADDR, 32'h10);
      t0 = n_begin;
      send(1'b0);
      chk("rx_async", n_begin - t0, 1);
      send(1'b1);
      chk("rx_sync", n_begin - t0, 2);
      wr(SCC_CTRL_ADDR, 32'h0);
      send(1'b0);
      chk("rx_off", n_begin - t0, 2);
      // Baud sources; subclock halved only outside the sub modes
      bcount(2'h2, 1'b0, 160, 10);
      bcount(2'h3, 1'b0, 256, 4);
      bcount(2'h1, 1'b0, 160, 20);
      bcount(2'h1, 1'b1, 160, 40);
      bcount(2'h0, 1'b0, 32, 32);
      for (int i = 0; i < 3; i++) begin
         wr(SCC_CTRL_ADDR, 32'h33);
         wr(SCC_BAUD_ADDR, 32'h3);
         lpv <= 3'h1 << i;
         repeat (3) @(posedge clk);
         lpv <= 3'h0;
         @(posedge clk);
         rdc("ctrl_lp", SCC_CTRL_ADDR, 32'h0);
         rdc("baud_lp", SCC_BAUD_ADDR, 32'h0);
      end
      wr(SCC_CTRL_ADDR, 32'hFF);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc("ctrl_rst2", SCC_CTRL_ADDR, 32'h0);
      rdc("mask_rst", SCC_IRQ_MASK_ADDR, 32'h0);
      complete_run();
   end
endmodule : tb_serial_control_clock_select
